// file: hw/clamp_coast_pkg.sv
// Shared constants and types for the clamp, coast and output configuration bank
package clamp_coast_pkg;

    // Register offsets on the serial port
    localparam logic [7:0] REG_CLAMP_COAST = 8'h11;
    localparam logic [7:0] REG_PRE_COAST   = 8'h12;
    localparam logic [7:0] REG_POST_COAST  = 8'h13;
    localparam logic [7:0] REG_OUT_PWR     = 8'h14;
    localparam logic [7:0] REG_SYNC_STAT   = 8'h15;

    // Reset values
    localparam logic [7:0] RST_CLAMP_COAST = 8'h08;
    localparam logic [7:0] RST_PRE_COAST   = 8'h00;
    localparam logic [7:0] RST_POST_COAST  = 8'h00;
    localparam logic [7:0] RST_OUT_PWR     = 8'hE2;
    localparam logic [7:0] RD_UNMAPPED     = 8'h00;

    // Clamp and coast control fields
    localparam int B_CLAMP_SRC = 7;
    localparam int B_CLAMP_RED = 6;
    localparam int B_CLAMP_GRN = 5;
    localparam int B_CLAMP_BLU = 4;
    localparam int B_COAST_EN  = 3;
    localparam int B_COAST_OVR = 2;
    localparam int B_COAST_POL = 1;

    // Output and power fields
    localparam int B_DRIVE_HI  = 7;
    localparam int B_DRIVE_LO  = 6;
    localparam int B_BW_300    = 5;
    localparam int B_CLK_INV   = 4;
    localparam int B_TRISTATE  = 3;
    localparam int B_HDCP_ADDR = 2;
    localparam int B_SLEEP_N   = 1;
    localparam int B_FMT_422   = 0;

    // Status fields
    localparam int B_HS_DET  = 7;
    localparam int B_SOG_DET = 6;
    localparam int B_VS_DET  = 5;

    // Serial port framing
    localparam int         SER_ADDR_W = 7;
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    localparam logic [3:0] LAST_BIT   = 4'h7;
    localparam logic [2:0] PIN_IDLE   = 3'h3;

    // Activity timeout
    localparam int MCLK_HZ         = 40_000_000;
    localparam int ACT_TIMEOUT_MS  = 50;
    localparam int ACT_TIMEOUT_CYC = ACT_TIMEOUT_MS * (MCLK_HZ / 1000);

    typedef enum logic [1:0] {DRIVE_LOW, DRIVE_MED, DRIVE_HIGH} drive_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } ser_state_t;

endpackage

// file: hw/activity_detect.sv
// Transition detector with idle timeout for one sync pin
`timescale 1ns/1ps
module activity_detect
    import clamp_coast_pkg::*;
#(
    parameter int TIMEOUT = ACT_TIMEOUT_CYC
)(
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rstn,
    // Pin and result
    input  wire logic i_pin,
    output logic      o_active
);

    localparam int CW = $clog2(TIMEOUT + 1);
    localparam logic [CW-1:0] LAST = CW'(TIMEOUT - 1);

    if (TIMEOUT < 2)
        $error("activity_detect: TIMEOUT must be at least 2");

    logic [2:0]    sync_r;
    logic          level_r;
    logic          seen_r;
    logic          active_r;
    logic [CW-1:0] idle_r;

    // Change counts once second and third stage agree
    wire agree   = (sync_r[1] == sync_r[2]);
    wire toggled = agree && seen_r && (sync_r[2] != level_r);

    // Pin synchroniser and settled level
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync_r  <= 3'h0;
            level_r <= 1'b0;
            seen_r  <= 1'b0;
        end
        else
        begin
            sync_r <= {sync_r[1:0], i_pin};
            if (agree)
            begin
                level_r <= sync_r[2];
                seen_r  <= 1'b1;
            end
        end
    end

    // Edge sets, silence clears; the edge wins
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            active_r <= 1'b0;
            idle_r   <= '0;
        end
        else if (toggled)
        begin
            active_r <= 1'b1;
            idle_r   <= '0;
        end
        else if (active_r)
        begin
            if (idle_r == LAST)
                active_r <= 1'b0;
            else
                idle_r <= idle_r + 1'b1;
        end
    end

    assign o_active = active_r;

endmodule

// file: hw/clamp_coast_output_cfg_regs.sv
// Clamp, coast, output and sync activity registers behind a two-wire serial slave
// Notes on behaviour
// - Clamp source 0 (reset) uses internal clamp timing from hsync trailing edge.
// - Clamp source 1 disables internal timing; channels clamp while external strobe active.
// - Per-channel reference bits red 6, green 5, blue 4; 0 ground, 1 midscale.
// - Coast enable 0 disables coast, 1 uses internal coast; resets to 1.
// - Override 0 lets chip pick coast polarity; 1 uses user value when disabled.
// - Polarity bit 0 active low, 1 active high; only when disabled and overridden.
// - Eight-bit pre-coast count of composite sync edges masked before vsync; reset 0.
// - Eight-bit post-coast count of hsync periods masked after vsync; reset 0.
// - Drive field: upper bit high, 01 medium, 00 low; resets 11.
// - Bandwidth bit 0 selects 10 MHz, 1 selects 300 MHz.
// - Clock invert acts on digital interface only; 0 data changes on falling edge.
// - Tristate bit 1 floats pixel data, sync and data enable outputs.
// - One bit supplies the content-protection slave address bit; reset 0.
// - Chip sleep control active low; 0 powers down, reset 1.
// - Format bit 0 gives 4:4:4, 1 gives 4:2:2 on 16 lines.
// - In 4:2:2 green carries luma, red chroma, blue output floats.
// - Hsync detect reads 1 on transitions, 0 when held constant.
// - Sync-on-green detect reads 1 on activity; plain video may set it.
// - Vsync detect reads 1 on transitions, 0 when held constant.
// - Analog presence is the OR of the three detect bits.
// - Registers reached over two-wire serial port; device is slave only.
`timescale 1ns/1ps
module clamp_coast_output_cfg_regs
    import clamp_coast_pkg::*;
#(
    parameter logic [SER_ADDR_W-1:0] DEV_ADDR    = 7'h4C, // arbitrary value
    parameter int                    ACT_TIMEOUT = ACT_TIMEOUT_CYC
)(
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rstn,
    // Two-wire serial port
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda_out,
    output logic      o_sda_oe,
    // Sync and clamp inputs
    input  wire logic i_hsync,
    input  wire logic i_sync_on_green_input,
    input  wire logic i_vsync,
    input  wire logic i_ext_clamp,
    input  wire logic i_int_clamp,
    input  wire logic i_coast_pol_auto,
    input  wire logic i_digital_active,
    // Clamp controls, order red green blue
    output logic       o_clamp_internal_en,
    output logic [2:0] o_clamp_active,
    output logic [2:0] o_clamp_midscale,
    // Coast controls
    output logic       o_coast_en,
    output logic       o_coast_pol_user,
    output logic       o_coast_active_high,
    output logic [7:0] o_pre_coast,
    output logic [7:0] o_post_coast,
    // Output stage and power
    output drive_t     o_drive,
    output logic       o_bw_300mhz,
    output logic       o_clk_invert,
    output logic       o_outputs_tristate,
    output logic       o_red_oe,
    output logic       o_green_oe,
    output logic       o_blue_oe,
    output logic       o_sync_oe,
    output logic       o_hdcp_addr,
    output logic       o_chip_sleep_n,
    output logic       o_fmt_422,
    // Sync activity
    output logic       o_hsync_active,
    output logic       o_sog_active,
    output logic       o_vsync_active,
    output logic       o_analog_present
);

    if (ACT_TIMEOUT < 2)
        $error("clamp_coast_output_cfg_regs: ACT_TIMEOUT must be at least 2");

    // Pointer step after each data byte
    function automatic logic [7:0] next_ptr(input logic [7:0] p);
        return p + 8'h01;
    endfunction

    // Drive strength decode
    function automatic drive_t decode_drive(input logic hi, input logic lo);
        if (hi)
            return DRIVE_HIGH;
        else if (lo)
            return DRIVE_MED;
        else
            return DRIVE_LOW;
    endfunction

    logic [7:0] cc_r;
    logic [7:0] pre_r;
    logic [7:0] post_r;
    logic [7:0] op_r;
    logic [7:0] stat;

    logic [2:0] p1_r;
    logic [2:0] p2_r;
    logic [2:0] p3_r;
    logic [2:0] filt_r;
    logic [2:0] prev_r;
    logic [2:0] filt_nxt;

    ser_state_t st_r;
    ser_state_t st_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic       rw_r;
    logic       rw_nxt;
    logic       oe_r;
    logic       oe_nxt;
    logic       wr_stb;
    logic [7:0] rd_data;
    logic       hs_act;
    logic       sog_act;
    logic       vs_act;

    // Three-stage pin sync: {ext_clamp, sda, scl}; value moves when stages 2 and 3 agree
    assign filt_nxt = (p2_r & p3_r) | (filt_r & (p2_r | p3_r));

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            p1_r   <= PIN_IDLE;
            p2_r   <= PIN_IDLE;
            p3_r   <= PIN_IDLE;
            filt_r <= PIN_IDLE;
            prev_r <= PIN_IDLE;
        end
        else
        begin
            p1_r   <= {i_ext_clamp, i_sda, i_scl};
            p2_r   <= p1_r;
            p3_r   <= p2_r;
            filt_r <= filt_nxt;
            prev_r <= filt_r;
        end
    end

    // Serial line events
    wire scl_f    = filt_r[0];
    wire sda_f    = filt_r[1];
    wire clamp_f  = filt_r[2];
    wire scl_rise = scl_f & ~prev_r[0];
    wire scl_fall = ~scl_f & prev_r[0];
    wire start_c  = scl_f & prev_r[0] & prev_r[1] & ~sda_f;
    wire stop_c   = scl_f & prev_r[0] & ~prev_r[1] & sda_f;

    // Read-back mux; unmapped offsets read zero
    assign stat = {hs_act, sog_act, vs_act, 5'h00};
    assign rd_data = (ptr_r == REG_CLAMP_COAST) ? cc_r   :
                     (ptr_r == REG_PRE_COAST)   ? pre_r  :
                     (ptr_r == REG_POST_COAST)  ? post_r :
                     (ptr_r == REG_OUT_PWR)     ? op_r   :
                     (ptr_r == REG_SYNC_STAT)   ? stat   : RD_UNMAPPED;

    // Slave byte engine: address, pointer, then data with auto-increment
    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        sh_nxt  = sh_r;
        ptr_nxt = ptr_r;
        rw_nxt  = rw_r;
        oe_nxt  = oe_r;
        wr_stb  = 1'b0;
        if (start_c)
        begin
            st_nxt  = ST_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b0;
        end
        else if (stop_c)
        begin
            st_nxt = ST_IDLE;
            oe_nxt = 1'b0;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE:
                    st_nxt = ST_IDLE;
                ST_ADDR, ST_PTR, ST_WR:
                    if (scl_rise)
                    begin
                        sh_nxt  = {sh_r[6:0], sda_f};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    else if (scl_fall && cnt_r == BYTE_BITS)
                    begin
                        cnt_nxt = 4'h0;
                        oe_nxt  = 1'b1;
                        if (st_r == ST_ADDR)
                        begin
                            rw_nxt = sh_r[0];
                            if (sh_r[7:1] == DEV_ADDR)
                                st_nxt = ST_ADDR_ACK;
                            else
                            begin
                                st_nxt = ST_IDLE;
                                oe_nxt = 1'b0;
                            end
                        end
                        else if (st_r == ST_PTR)
                        begin
                            ptr_nxt = sh_r;
                            st_nxt  = ST_PTR_ACK;
                        end
                        else
                        begin
                            wr_stb  = 1'b1;
                            ptr_nxt = next_ptr(ptr_r);
                            st_nxt  = ST_WR_ACK;
                        end
                    end
                ST_ADDR_ACK, ST_PTR_ACK, ST_WR_ACK:
                    if (scl_fall)
                    begin
                        if (st_r == ST_ADDR_ACK && rw_r)
                        begin
                            st_nxt = ST_RD;
                            sh_nxt = rd_data;
                            oe_nxt = ~rd_data[7];
                        end
                        else
                        begin
                            st_nxt = (st_r == ST_ADDR_ACK) ? ST_PTR : ST_WR;
                            oe_nxt = 1'b0;
                        end
                    end
                ST_RD:
                    if (scl_fall)
                    begin
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == LAST_BIT)
                        begin
                            st_nxt  = ST_RD_ACK;
                            oe_nxt  = 1'b0;
                            ptr_nxt = next_ptr(ptr_r);
                        end
                        else
                        begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            oe_nxt = ~sh_r[6];
                        end
                    end
                ST_RD_ACK:
                    if (scl_rise && sda_f)
                        st_nxt = ST_IDLE;
                    else if (scl_fall)
                    begin
                        st_nxt  = ST_RD;
                        cnt_nxt = 4'h0;
                        sh_nxt  = rd_data;
                        oe_nxt  = ~rd_data[7];
                    end
            endcase
        end
    end

    // Serial engine state
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            st_r  <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r  <= 8'h00;
            ptr_r <= 8'h00;
            rw_r  <= 1'b0;
            oe_r  <= 1'b0;
        end
        else
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r  <= sh_nxt;
            ptr_r <= ptr_nxt;
            rw_r  <= rw_nxt;
            oe_r  <= oe_nxt;
        end
    end

    // Open-drain data: only ever pulls low
    assign o_sda_out = 1'b0;
    assign o_sda_oe  = oe_r;

    // Write strobes; status offset takes no writes
    wire wr_cc   = wr_stb && (ptr_r == REG_CLAMP_COAST);
    wire wr_pre  = wr_stb && (ptr_r == REG_PRE_COAST);
    wire wr_post = wr_stb && (ptr_r == REG_POST_COAST);
    wire wr_op   = wr_stb && (ptr_r == REG_OUT_PWR);

    // Configuration registers; bit 0 of clamp/coast is reserved and stays 0
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cc_r   <= RST_CLAMP_COAST;
            pre_r  <= RST_PRE_COAST;
            post_r <= RST_POST_COAST;
            op_r   <= RST_OUT_PWR;
        end
        else
        begin
            if (wr_cc)
                cc_r <= {sh_r[7:1], 1'b0};
            if (wr_pre)
                pre_r <= sh_r;
            if (wr_post)
                post_r <= sh_r;
            if (wr_op)
                op_r <= sh_r;
        end
    end

    // Clamp source and references
    assign o_clamp_internal_en = ~cc_r[B_CLAMP_SRC];
    assign o_clamp_active = cc_r[B_CLAMP_SRC] ? {3{clamp_f}}
                                              : {3{i_int_clamp}};
    assign o_clamp_midscale = {cc_r[B_CLAMP_RED], cc_r[B_CLAMP_GRN],
                               cc_r[B_CLAMP_BLU]};

    // Coast; user polarity honoured only with coast off and override set
    assign o_coast_en = cc_r[B_COAST_EN];
    assign o_coast_pol_user = ~cc_r[B_COAST_EN] & cc_r[B_COAST_OVR];
    assign o_coast_active_high = o_coast_pol_user ? cc_r[B_COAST_POL]
                                                  : i_coast_pol_auto;
    assign o_pre_coast  = pre_r;
    assign o_post_coast = post_r;

    // Output stage
    assign o_drive = decode_drive(op_r[B_DRIVE_HI], op_r[B_DRIVE_LO]);
    assign o_bw_300mhz = op_r[B_BW_300];
    assign o_clk_invert = op_r[B_CLK_INV] & i_digital_active;
    assign o_outputs_tristate = op_r[B_TRISTATE];
    assign o_red_oe   = ~op_r[B_TRISTATE];
    assign o_green_oe = ~op_r[B_TRISTATE];
    assign o_sync_oe  = ~op_r[B_TRISTATE];
    assign o_blue_oe  = ~op_r[B_TRISTATE] & ~op_r[B_FMT_422];
    assign o_hdcp_addr = op_r[B_HDCP_ADDR];
    assign o_chip_sleep_n = op_r[B_SLEEP_N];
    assign o_fmt_422 = op_r[B_FMT_422];

    // Sync activity detectors
    activity_detect #(.TIMEOUT(ACT_TIMEOUT)) u_hs_det (
        .i_mclk   (i_mclk),
        .i_rstn   (i_rstn),
        .i_pin    (i_hsync),
        .o_active (hs_act)
    );

    activity_detect #(.TIMEOUT(ACT_TIMEOUT)) u_sog_det (
        .i_mclk   (i_mclk),
        .i_rstn   (i_rstn),
        .i_pin    (i_sync_on_green_input),
        .o_active (sog_act)
    );

    activity_detect #(.TIMEOUT(ACT_TIMEOUT)) u_vs_det (
        .i_mclk   (i_mclk),
        .i_rstn   (i_rstn),
        .i_pin    (i_vsync),
        .o_active (vs_act)
    );

    assign o_hsync_active   = hs_act;
    assign o_sog_active     = sog_act;
    assign o_vsync_active   = vs_act;
    assign o_analog_present = hs_act | sog_act | vs_act;

endmodule

// file: tb/cfg_regs_props.sv
// Port assertions for the clamp, coast and output register bank
`timescale 1ns/1ps
module cfg_regs_props
    import clamp_coast_pkg::*;
(
    // Clock, reset and watched inputs
    input wire logic       i_mclk,
    input wire logic       i_rstn,
    input wire logic       i_hsync,
    input wire logic       i_ext_clamp,
    input wire logic       i_int_clamp,
    input wire logic       i_coast_pol_auto,
    // Watched outputs
    input wire logic       o_sda_out,
    input wire logic       o_clamp_internal_en,
    input wire logic [2:0] o_clamp_active,
    input wire logic       o_coast_en,
    input wire logic       o_coast_pol_user,
    input wire logic       o_coast_active_high,
    input wire logic       o_outputs_tristate,
    input wire logic       o_blue_oe,
    input wire logic       o_fmt_422,
    input wire logic       o_hsync_active,
    input wire logic       o_sog_active,
    input wire logic       o_vsync_active,
    input wire logic       o_analog_present
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    // Output and source relations
    a_sda_open_drain: assert property (o_sda_out == 1'b0)
        else $error("serial data output value not zero");
    a_int_clamp_follow: assert property ((o_clamp_internal_en && $stable(i_int_clamp))[*3]
        |-> o_clamp_active == {3{i_int_clamp}})
        else $error("clamp does not follow internal timing");
    a_ext_clamp_follow: assert property ((!o_clamp_internal_en && $stable(i_ext_clamp))[*6]
        |-> o_clamp_active == {3{i_ext_clamp}})
        else $error("clamp does not follow external strobe");
    a_user_pol_gate: assert property (o_coast_pol_user |-> !o_coast_en)
        else $error("user coast polarity while coast enabled");
    a_auto_pol_used: assert property ((!o_coast_pol_user && $stable(i_coast_pol_auto))[*2]
        |-> o_coast_active_high == i_coast_pol_auto)
        else $error("coast polarity not taken from chip");
    a_blue_oe_422: assert property (o_blue_oe == (!o_outputs_tristate && !o_fmt_422))
        else $error("blue output enable wrong");
    a_present_or: assert property (o_analog_present ==
        (o_hsync_active || o_sog_active || o_vsync_active))
        else $error("analog presence not the detect OR");
    a_hs_edge_sets: assert property ($changed(i_hsync) |-> ##[1:8] o_hsync_active)
        else $error("hsync activity not flagged");

    // Main scenarios
    c_ext_clamp: cover property (!o_clamp_internal_en && o_clamp_active == 3'h7);
    c_user_pol: cover property (o_coast_pol_user && o_coast_active_high);
    c_hs_active: cover property ($rose(o_hsync_active));
endmodule

bind clamp_coast_output_cfg_regs cfg_regs_props i_props (
    .i_mclk, .i_rstn, .i_hsync, .i_ext_clamp, .i_int_clamp, .i_coast_pol_auto, .o_sda_out,
    .o_clamp_internal_en, .o_clamp_active, .o_coast_en, .o_coast_pol_user,
    .o_coast_active_high, .o_outputs_tristate, .o_blue_oe, .o_fmt_422, .o_hsync_active,
    .o_sog_active, .o_vsync_active, .o_analog_present
);

// file: tb/serial_host_model.sv
// Host controller model on the two-wire serial port
`timescale 1ns/1ps
module serial_host_model
    import clamp_coast_pkg::*;
#(
    parameter logic [SER_ADDR_W-1:0] DEV_ADDR = 7'h4C // arbitrary value
)(
    // Clock and wired line level
    input  wire logic i_mclk,
    input  wire logic i_sda_line,
    // Host drive, high means released
    output logic      o_scl,
    output logic      o_sda_m
);
    int nack_cnt;

    // Idle bus is released high
    initial
    begin
        o_scl = 1'b1;
        o_sda_m = 1'b1;
        nack_cnt = 0;
    end
    // One phase of eight clocks, twice the minimum
    task automatic ph(input logic c, input logic s);
        o_scl = c;
        o_sda_m = s;
        repeat (8) @(negedge i_mclk);
    endtask
    // Data changes only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        ph(1'b0, b);
        ph(1'b1, b);
        r = i_sda_line;
        ph(1'b0, b);
    endtask
    // Start or repeated start, then stop
    task automatic start();
        ph(o_scl, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        ph(1'b0, 1'b0);
    endtask
    task automatic stop();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    // Byte out, most significant bit first; a missing acknowledge is counted
    task automatic send(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        if (r)
            nack_cnt++;
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        start();
        send({DEV_ADDR, 1'b0});
        send(a);
        send(d);
        stop();
    endtask
    // Pointer write, repeated start, one byte ended by a not-acknowledge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic r;
        start();
        send({DEV_ADDR, 1'b0});
        send(a);
        start();
        send({DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
        stop();
    endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the clamp, coast and output register bank
`timescale 1ns/1ps
module tb;
    import clamp_coast_pkg::*;
    localparam int TMO = 64;
    // Clock, reset, serial port and pins
    logic        i_mclk, i_rstn, i_scl, sda_m, o_sda_out, o_sda_oe;
    wire         i_sda = ~o_sda_oe & sda_m;
    logic        i_hsync, i_sync_on_green_input, i_vsync, i_ext_clamp, i_int_clamp;
    logic        i_coast_pol_auto, i_digital_active;
    // Design outputs
    logic        o_clamp_internal_en, o_coast_en, o_coast_pol_user, o_coast_active_high;
    logic [2:0]  o_clamp_active, o_clamp_midscale;
    logic [7:0]  o_pre_coast, o_post_coast;
    drive_t      o_drive;
    logic        o_bw_300mhz, o_clk_invert, o_outputs_tristate, o_red_oe, o_green_oe;
    logic        o_blue_oe, o_sync_oe, o_hdcp_addr, o_chip_sleep_n, o_fmt_422;
    logic        o_hsync_active, o_sog_active, o_vsync_active, o_analog_present;
    wire  [3:0]  det = {o_hsync_active, o_sog_active, o_vsync_active, o_analog_present};
    // Bench model state
    int          err_count, checks, tcnt;
    logic [7:0]  m_reg [4];
    logic [7:0]  d;
    logic [2:0]  act_en, exp_act;
    logic [15:0] lfsr;

    clamp_coast_output_cfg_regs #(.ACT_TIMEOUT(TMO)) i_dut (
        .i_mclk, .i_rstn, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .i_hsync,
        .i_sync_on_green_input, .i_vsync, .i_ext_clamp, .i_int_clamp, .i_coast_pol_auto,
        .i_digital_active, .o_clamp_internal_en, .o_clamp_active, .o_clamp_midscale,
        .o_coast_en, .o_coast_pol_user, .o_coast_active_high, .o_pre_coast, .o_post_coast,
        .o_drive, .o_bw_300mhz, .o_clk_invert, .o_outputs_tristate, .o_red_oe, .o_green_oe,
        .o_blue_oe, .o_sync_oe, .o_hdcp_addr, .o_chip_sleep_n, .o_fmt_422, .o_hsync_active,
        .o_sog_active, .o_vsync_active, .o_analog_present
    );
    serial_host_model i_host (.i_mclk, .i_sda_line(i_sda), .o_scl(i_scl), .o_sda_m(sda_m));

    // 40 MHz clock
    initial
    begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    // Enabled sync pins toggle every fourth clock
    always @(negedge i_mclk)
    begin
        tcnt <= tcnt + 1;
        if (tcnt % 4 == 0)
            {i_hsync, i_sync_on_green_input, i_vsync} <=
                {i_hsync, i_sync_on_green_input, i_vsync} ^ act_en;
    end
    // Hang guard
    initial
    begin
        repeat (100000) @(posedge i_mclk);
        err_count++;
        give_verdict();
    end

    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic give_verdict();
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Register read against the model
    task automatic rd_cmp(input logic [7:0] a);
        logic [7:0] v, e;
        e = 8'h00;
        if (a == 8'h11)
            e = m_reg[0] & 8'hFE;
        else if (a >= 8'h12 && a <= 8'h14)
            e = m_reg[2'(a - 8'h11)];
        else if (a == 8'h15)
            e = {exp_act, 5'h00};
        i_host.read_reg(a, v);
        check("register read", e, v);
    endtask
    // Decoded outputs against the model
    task automatic check_ports();
        logic [7:0] c, p, e, s;
        c = m_reg[0];
        p = m_reg[3];
        e = {1'b0, ~c[7], c[6:4], c[7] ? {3{i_ext_clamp}} : {3{i_int_clamp}}};
        s = {1'b0, o_clamp_internal_en, o_clamp_midscale, o_clamp_active};
        check("clamp", e, s);
        e = {3'h0, ~p[3], ~p[3], c[3], ~c[3] & c[2], (~c[3] & c[2]) ? c[1] : i_coast_pol_auto};
        s = {3'h0, o_green_oe, o_sync_oe, o_coast_en, o_coast_pol_user, o_coast_active_high};
        check("coast", e, s);
        e = {p[5], p[4] & i_digital_active, p[3:0], ~p[3], ~p[3] & ~p[0]};
        s = {o_bw_300mhz, o_clk_invert, o_outputs_tristate, o_hdcp_addr, o_chip_sleep_n,
             o_fmt_422, o_red_oe, o_blue_oe};
        check("output stage", e, s);
        check("drive", {6'h00, p[7] ? 2'h2 : {1'b0, p[6]}}, {6'h00, o_drive});
        check("pre coast", m_reg[1], o_pre_coast);
        check("post coast", m_reg[2], o_post_coast);
    endtask

    // Main sequence
    initial
    begin
        i_rstn = 1'b0;
        {i_hsync, i_sync_on_green_input, i_vsync, i_ext_clamp, i_int_clamp} = 5'h00;
        {i_coast_pol_auto, i_digital_active} = 2'h0;
        act_en = 3'h0;
        exp_act = 3'h0;
        tcnt = 0;
        err_count = 0;
        checks = 0;
        lfsr = 16'hC477;
        m_reg = '{8'h08, 8'h00, 8'h00, 8'hE2};
        repeat (5) @(negedge i_mclk);
        i_rstn = 1'b1;
        repeat (8) @(negedge i_mclk);
        check_ports();
        for (logic [7:0] a = 8'h10; a < 8'h17; a++)
            rd_cmp(a);
        // Random settings, all drive codes, coast disable on odd passes
        for (int i = 0; i < 5; i++)
        begin
            for (logic [7:0] a = 8'h11; a < 8'h16; a++)
            begin
                lfsr = step(lfsr);
                d = lfsr[7:0];
                if (a == 8'h14 && i < 4)
                    d[7:6] = 2'(i);
                if (a == 8'h11 && (i[0] || !d[3]))
                    d[3:1] = 3'h3;
                i_host.write_reg(a, d);
                if (a < 8'h15)
                    m_reg[2'(a - 8'h11)] = d;
            end
            lfsr = step(lfsr);
            {i_ext_clamp, i_int_clamp, i_coast_pol_auto, i_digital_active} = lfsr[3:0];
            for (logic [7:0] a = 8'h11; a < 8'h16; a++)
                rd_cmp(a);
            check_ports();
        end
        // Each sync pin active, then held still past the timeout
        for (int k = 0; k < 3; k++)
        begin
            act_en = 3'h4 >> k;
            exp_act = act_en;
            repeat (20) @(negedge i_mclk);
            rd_cmp(REG_SYNC_STAT);
            check("presence", {4'h0, exp_act, exp_act != 3'h0}, {4'h0, det});
            act_en = 3'h0;
            exp_act = 3'h0;
            repeat (TMO + 40) @(negedge i_mclk);
            rd_cmp(REG_SYNC_STAT);
            check("presence", 8'h00, {4'h0, det});
        end
        check("missed acks", 8'h00, 8'(i_host.nack_cnt));
        give_verdict();
    end
endmodule
